// ### rtl/frsf_top.sv
// Result status flag logic with AXI4-Lite register access
//
// The address map and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// - Set past-last-sector flag when access goes beyond the cylinder's last sector.
// - First byte bits 6 and 3, second byte bit 7, always read zero.
// - Set CRC fault flag on an ID field or data field CRC failure.
// - Set host-late flag when the host misses a transfer in time.
// - Set not-located flag when read, write deleted or scan misses the sector.
// - Read ID sets not-located when no error-free ID field is read.
// - Read track sets not-located when the starting sector is not found.
// - Set write-blocked when protect tab active during write or format commands.
// - Set ID-header-lost when two index pulses pass without an ID mark.
// - Payload-mark-absent is set together with ID-header-lost.
// - Read data or scan sets deleted flag on a deleted data mark.
// - Set payload CRC fault only for a data field CRC failure.
// - With not-located, flag track mismatch when read cylinder differs from target.
// - Scan sets equal-hit flag when the equal condition is met.
// - Scan sets no-match flag when no sector meets the condition.
// - With not-located, flag bad track when cylinder differs and the read cylinder is FF.
// - Set payload-mark-absent when no data address mark is found.
// - Termination code is 00 only for normal completion, abnormal with errors.
module frsf_top #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Command sequencing
  input wire logic cmd_start,
  input wire frsf_pkg::frsf_cmd_e cmd_kind,
  input wire logic cmd_done,
  input wire logic [7:0] target_cyl,
  // Drive side
  input wire logic protect_tab_input,
  input wire frsf_pkg::frsf_events_s ev,
  // Interrupt
  output logic irq
);

  frsf_pkg::frsf_state_s s_reg;
  frsf_pkg::frsf_state_s s_next;

  logic exec;
  logic k_read, k_write, k_wdel, k_rid, k_rtrk, k_scan, k_fmt;
  logic mis_now, bad_now, mis_any, bad_any, not_loc;
  logic id_lost_ev;
  logic [7:0] st1_set, st2_set;
  logic have_aw, have_w;
  logic [7:0] waddr, raddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic [31:0] rd_val;
  logic rd_ok;
  logic rd_two;
  logic [frsf_pkg::IRQ_W-1:0] irq_set, irq_clr;

  // Command classes and cylinder comparison
  always_comb
  begin
    exec = (s_reg.phase == frsf_pkg::PH_EXEC);
    k_read = (s_reg.kind == frsf_pkg::CMD_READ_DATA);
    k_write = (s_reg.kind == frsf_pkg::CMD_WRITE_DATA);
    k_wdel = (s_reg.kind == frsf_pkg::CMD_WRITE_DELETED);
    k_rid = (s_reg.kind == frsf_pkg::CMD_READ_ID);
    k_rtrk = (s_reg.kind == frsf_pkg::CMD_READ_TRACK);
    k_scan = (s_reg.kind == frsf_pkg::CMD_SCAN);
    k_fmt = (s_reg.kind == frsf_pkg::CMD_FORMAT_TRACK);
    mis_now = ev.cyl_valid && (ev.read_cyl != target_cyl);
    bad_now = mis_now && (ev.read_cyl == frsf_pkg::BAD_TRACK_CYL);
    mis_any = mis_now || s_reg.cyl_mismatch;
    bad_any = ev.cyl_valid ? bad_now : s_reg.cyl_bad;
    not_loc = (ev.sector_miss && (k_read || k_wdel || k_scan))
      || (ev.id_read_fail && k_rid)
      || (ev.start_sector_miss && k_rtrk);
    id_lost_ev = ev.index_pulse && !ev.id_mark_found
      && (s_reg.idx_cnt == frsf_pkg::INDEX_LIMIT - 2'h1);
  end

  // Flags that this cycle's events raise, only during execution
  always_comb
  begin
    st1_set = 8'h00;
    st2_set = 8'h00;
    st1_set[frsf_pkg::S1_PAST_LAST] = ev.past_last_sector;
    st1_set[frsf_pkg::S1_CRC_ANY] = ev.id_crc_fail || ev.data_crc_fail;
    st1_set[frsf_pkg::S1_HOST_LATE] = ev.host_late;
    st1_set[frsf_pkg::S1_NOT_LOCATED] = not_loc;
    st1_set[frsf_pkg::S1_WRITE_BLOCKED] = protect_tab_input
      && (k_write || k_wdel || k_fmt);
    st1_set[frsf_pkg::S1_ID_LOST] = id_lost_ev;
    st2_set[frsf_pkg::S2_DELETED] = ev.deleted_mark && (k_read || k_scan);
    st2_set[frsf_pkg::S2_CRC_PAYLOAD] = ev.data_crc_fail;
    st2_set[frsf_pkg::S2_TRACK_MISMATCH] = not_loc && mis_any;
    st2_set[frsf_pkg::S2_EQUAL_HIT] = ev.scan_equal && k_scan;
    st2_set[frsf_pkg::S2_NO_MATCH] = ev.scan_none && k_scan;
    st2_set[frsf_pkg::S2_BAD_TRACK] = not_loc && mis_any && bad_any;
    st2_set[frsf_pkg::S2_MARK_ABSENT] = ev.data_mark_miss || id_lost_ev;
    if (!exec)
    begin
      st1_set = 8'h00;
      st2_set = 8'h00;
    end
  end

  // Address and data of a write, from the holding fields or the bus
  always_comb
  begin
    have_aw = s_reg.aw_got || (s_axi_awvalid && s_reg.awready);
    have_w = s_reg.w_got || (s_axi_wvalid && s_reg.wready);
    waddr = s_reg.aw_got ? s_reg.aw_addr : s_axi_awaddr[7:0];
    wdata = s_reg.w_got ? s_reg.w_data : s_axi_wdata;
    wstrb = s_reg.w_got ? s_reg.w_strb : s_axi_wstrb;
    raddr = s_axi_araddr[7:0];
  end

  // Read decode
  always_comb
  begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    rd_two = 1'b0;
    if (raddr == frsf_pkg::OFS_STATUS_ONE)
    begin
      rd_val[7:0] = s_reg.st1 & ~frsf_pkg::S1_ZERO_MASK;
    end
    else if (raddr == frsf_pkg::OFS_STATUS_TWO)
    begin
      rd_val[7:0] = s_reg.st2 & ~frsf_pkg::S2_ZERO_MASK;
      rd_two = 1'b1;
    end
    else if (raddr == frsf_pkg::OFS_CMD_STATUS)
    begin
      rd_val[frsf_pkg::CS_TERM_HI:frsf_pkg::CS_TERM_LO] = s_reg.term;
      rd_val[frsf_pkg::CS_RESULT] = (s_reg.phase == frsf_pkg::PH_RESULT);
      rd_val[frsf_pkg::CS_BUSY] = exec;
    end
    else if (raddr == frsf_pkg::OFS_IRQ_STATUS)
    begin
      rd_val[frsf_pkg::IRQ_W-1:0] = s_reg.irq_status;
    end
    else if (raddr == frsf_pkg::OFS_IRQ_ENABLE)
    begin
      rd_val[frsf_pkg::IRQ_W-1:0] = s_reg.irq_enable;
    end
    else if (raddr == frsf_pkg::OFS_IRQ_CLEAR)
    begin
      rd_val = 32'h0000_0000; // Write-only, reads zero
    end
    else
    begin
      rd_ok = 1'b0;
    end
  end

  // Next state
  always_comb
  begin
    s_next = s_reg;
    irq_set = '0;
    irq_clr = '0;
    // Command phases and flag accumulation
    case (s_reg.phase)
      frsf_pkg::PH_IDLE, frsf_pkg::PH_RESULT:
      begin
        if (cmd_start)
        begin
          s_next.phase = frsf_pkg::PH_EXEC;
          s_next.kind = cmd_kind;
          s_next.st1 = 8'h00;
          s_next.st2 = 8'h00;
          s_next.term = frsf_pkg::TERM_NORMAL;
          s_next.idx_cnt = 2'h0;
          s_next.cyl_mismatch = 1'b0;
          s_next.cyl_bad = 1'b0;
        end
      end
      frsf_pkg::PH_EXEC:
      begin
        s_next.st1 = (s_reg.st1 | st1_set) & ~frsf_pkg::S1_ZERO_MASK;
        s_next.st2 = (s_reg.st2 | st2_set) & ~frsf_pkg::S2_ZERO_MASK;
        if (ev.id_mark_found)
          s_next.idx_cnt = 2'h0;
        else if (ev.index_pulse && s_reg.idx_cnt != frsf_pkg::INDEX_LIMIT)
          s_next.idx_cnt = s_reg.idx_cnt + 2'h1;
        if (ev.cyl_valid)
        begin
          s_next.cyl_mismatch = mis_now;
          s_next.cyl_bad = bad_now;
        end
        if (cmd_done)
        begin
          s_next.phase = frsf_pkg::PH_RESULT;
          irq_set[frsf_pkg::IRQ_CMD_END] = 1'b1;
          if ((s_next.st1 != 8'h00) || ((s_next.st2 & frsf_pkg::S2_ERROR_MASK) != 8'h00))
          begin
            s_next.term = frsf_pkg::TERM_ABNORMAL;
            irq_set[frsf_pkg::IRQ_ABNORMAL] = 1'b1;
          end
          else
          begin
            s_next.term = frsf_pkg::TERM_NORMAL;
          end
        end
      end
      default:
      begin
        s_next.phase = frsf_pkg::PH_IDLE;
      end
    endcase
    // Write channels: hold whichever arrives first
    if (s_axi_awvalid && s_reg.awready)
    begin
      s_next.aw_got = 1'b1;
      s_next.aw_addr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && s_reg.wready)
    begin
      s_next.w_got = 1'b1;
      s_next.w_data = s_axi_wdata;
      s_next.w_strb = s_axi_wstrb;
    end
    if (s_reg.bvalid && s_axi_bready)
      s_next.bvalid = 1'b0;
    if (have_aw && have_w && !s_reg.bvalid)
    begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = frsf_pkg::RESP_OKAY;
      if (waddr == frsf_pkg::OFS_IRQ_CLEAR)
      begin
        if (wstrb[0])
          irq_clr = wdata[frsf_pkg::IRQ_W-1:0];
      end
      else if (waddr == frsf_pkg::OFS_IRQ_ENABLE)
      begin
        if (wstrb[0])
          s_next.irq_enable = wdata[frsf_pkg::IRQ_W-1:0];
      end
      else if (waddr == frsf_pkg::OFS_STATUS_ONE || waddr == frsf_pkg::OFS_STATUS_TWO
        || waddr == frsf_pkg::OFS_CMD_STATUS || waddr == frsf_pkg::OFS_IRQ_STATUS)
      begin
        s_next.bresp = frsf_pkg::RESP_OKAY; // Read-only, write ignored
      end
      else
      begin
        s_next.bresp = frsf_pkg::RESP_SLVERR;
      end
    end
    // Read channel; reading the second byte ends the result phase
    if (s_reg.rvalid && s_axi_rready)
      s_next.rvalid = 1'b0;
    if (s_axi_arvalid && s_reg.arready)
    begin
      s_next.rvalid = 1'b1;
      s_next.rdata = rd_val;
      s_next.rresp = rd_ok ? frsf_pkg::RESP_OKAY : frsf_pkg::RESP_SLVERR;
      if (rd_two && s_reg.phase == frsf_pkg::PH_RESULT && !cmd_start)
        s_next.phase = frsf_pkg::PH_IDLE;
    end
    // Sticky interrupt status, set wins over clear
    s_next.irq_status = (s_reg.irq_status & ~irq_clr) | irq_set;
    s_next.irq = |(s_next.irq_status & s_next.irq_enable);
    s_next.awready = !s_next.aw_got && !s_next.bvalid;
    s_next.wready = !s_next.w_got && !s_next.bvalid;
    s_next.arready = !s_next.rvalid;
  end

  // State register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_reg <= '0;
      s_reg.phase <= frsf_pkg::PH_IDLE;
      s_reg.kind <= frsf_pkg::CMD_OTHER;
      s_reg.awready <= 1'b1;
      s_reg.wready <= 1'b1;
      s_reg.arready <= 1'b1;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready = s_reg.wready;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign irq = s_reg.irq;

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_past_last: assert property (exec && ev.past_last_sector |=> s_reg.st1[frsf_pkg::S1_PAST_LAST])
    else $error("past last sector flag not set");
  chk_zero_bits: assert property ((s_reg.st1 & frsf_pkg::S1_ZERO_MASK) == 8'h00
    && (s_reg.st2 & frsf_pkg::S2_ZERO_MASK) == 8'h00)
    else $error("fixed zero bit is set");
  chk_crc_any: assert property (exec && (ev.id_crc_fail || ev.data_crc_fail)
    |=> s_reg.st1[frsf_pkg::S1_CRC_ANY])
    else $error("crc fault flag not set");
  chk_host_late: assert property (exec && ev.host_late |=> s_reg.st1[frsf_pkg::S1_HOST_LATE])
    else $error("host late flag not set");
  chk_not_located: assert property (exec && ev.sector_miss && k_read
    |=> s_reg.st1[frsf_pkg::S1_NOT_LOCATED])
    else $error("sector not located flag not set");
  chk_write_blocked: assert property (exec && protect_tab_input && k_write
    |=> s_reg.st1[frsf_pkg::S1_WRITE_BLOCKED])
    else $error("write blocked flag not set");
  chk_id_lost: assert property (exec && ev.index_pulse && !ev.id_mark_found
    && !ev.cyl_valid ##1 exec && ev.index_pulse && !ev.id_mark_found && !cmd_start
    |=> s_reg.st1[frsf_pkg::S1_ID_LOST] && s_reg.st2[frsf_pkg::S2_MARK_ABSENT])
    else $error("id header lost not flagged after two index pulses");
  chk_id_pair: assert property (s_reg.st1[frsf_pkg::S1_ID_LOST]
    |-> s_reg.st2[frsf_pkg::S2_MARK_ABSENT])
    else $error("id lost without mark absent");
  chk_payload_crc: assert property ($rose(s_reg.st2[frsf_pkg::S2_CRC_PAYLOAD])
    |-> $past(ev.data_crc_fail))
    else $error("payload crc set without data crc failure");
  chk_bad_track: assert property ($rose(s_reg.st2[frsf_pkg::S2_BAD_TRACK])
    |-> s_reg.st2[frsf_pkg::S2_TRACK_MISMATCH] && s_reg.st1[frsf_pkg::S1_NOT_LOCATED])
    else $error("bad track without mismatch");
  chk_scan_eq: assert property (exec && k_scan && ev.scan_equal
    |=> s_reg.st2[frsf_pkg::S2_EQUAL_HIT])
    else $error("scan equal flag not set");
  chk_term_code: assert property (exec && cmd_done
    |=> s_reg.term == ((s_reg.st1 != 8'h00 || (s_reg.st2 & frsf_pkg::S2_ERROR_MASK) != 8'h00)
    ? frsf_pkg::TERM_ABNORMAL : frsf_pkg::TERM_NORMAL))
    else $error("termination code wrong");
  chk_clear_start: assert property (!exec && cmd_start
    |=> s_reg.st1 == 8'h00 && s_reg.st2 == 8'h00)
    else $error("flags not cleared at command start");
  chk_hold_result: assert property (s_reg.phase == frsf_pkg::PH_RESULT && !cmd_start
    |=> $stable(s_reg.st1) && $stable(s_reg.st2))
    else $error("flags changed in result phase");
  chk_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> s_axi_bvalid)
    else $error("write response late");

  cov_abnormal: cover property (exec && cmd_done ##1 s_reg.term == frsf_pkg::TERM_ABNORMAL);
  cov_normal: cover property (exec && cmd_done ##1 s_reg.term == frsf_pkg::TERM_NORMAL);
  cov_bad_track: cover property (s_reg.st2[frsf_pkg::S2_BAD_TRACK]);
  cov_irq: cover property (irq ##[1:20] !irq);

endmodule : frsf_top

// ### rtl/frsf_pkg.sv
// Package of constants and types for the floppy result status flags block
package frsf_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_STATUS_ONE = 8'h00;
  localparam logic [7:0] OFS_STATUS_TWO = 8'h04;
  localparam logic [7:0] OFS_CMD_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h10;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h14;
  // First result status byte fields
  localparam int S1_PAST_LAST = 7;
  localparam int S1_CRC_ANY = 5;
  localparam int S1_HOST_LATE = 4;
  localparam int S1_NOT_LOCATED = 2;
  localparam int S1_WRITE_BLOCKED = 1;
  localparam int S1_ID_LOST = 0;
  localparam logic [7:0] S1_ZERO_MASK = 8'h48;
  // Second result status byte fields
  localparam int S2_DELETED = 6;
  localparam int S2_CRC_PAYLOAD = 5;
  localparam int S2_TRACK_MISMATCH = 4;
  localparam int S2_EQUAL_HIT = 3;
  localparam int S2_NO_MATCH = 2;
  localparam int S2_BAD_TRACK = 1;
  localparam int S2_MARK_ABSENT = 0;
  localparam logic [7:0] S2_ZERO_MASK = 8'h80;
  localparam logic [7:0] S2_ERROR_MASK = 8'h37;
  // Cylinder value that marks a bad track
  localparam logic [7:0] BAD_TRACK_CYL = 8'hff;
  // Index pulses seen without an ID mark before giving up
  localparam logic [1:0] INDEX_LIMIT = 2'h2;
  // Command status byte layout and termination codes
  localparam int CS_TERM_HI = 7;
  localparam int CS_TERM_LO = 6;
  localparam int CS_RESULT = 1;
  localparam int CS_BUSY = 0;
  localparam logic [1:0] TERM_NORMAL = 2'h0;
  localparam logic [1:0] TERM_ABNORMAL = 2'h1;
  // Interrupt bits
  localparam int IRQ_W = 2;
  localparam int IRQ_CMD_END = 0;
  localparam int IRQ_ABNORMAL = 1;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    CMD_READ_DATA, CMD_WRITE_DATA, CMD_WRITE_DELETED, CMD_READ_ID,
    CMD_READ_TRACK, CMD_SCAN, CMD_FORMAT_TRACK, CMD_OTHER
  } frsf_cmd_e;

  typedef enum logic [1:0] {PH_IDLE, PH_EXEC, PH_RESULT} frsf_phase_e;

  // Events from the read path and the transfer logic, one-cycle pulses
  typedef struct packed {
    logic past_last_sector;
    logic id_crc_fail;
    logic data_crc_fail;
    logic host_late;
    logic sector_miss;
    logic id_read_fail;
    logic start_sector_miss;
    logic index_pulse;
    logic id_mark_found;
    logic deleted_mark;
    logic scan_equal;
    logic scan_none;
    logic data_mark_miss;
    logic cyl_valid;
    logic [7:0] read_cyl;
  } frsf_events_s;

  // Whole state of the top module
  typedef struct packed {
    frsf_phase_e phase;
    frsf_cmd_e kind;
    logic [7:0] st1;
    logic [7:0] st2;
    logic [1:0] term;
    logic [1:0] idx_cnt;
    logic cyl_mismatch;
    logic cyl_bad;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_enable;
    logic irq;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } frsf_state_s;
endpackage : frsf_pkg

// ### bench/frsf_drive_model.sv
// Drive-side model that turns bench pulse requests into read path events
`timescale 1ns/1ps
module frsf_drive_model (
  // Clock
  input wire logic aclk,
  // Requests from the bench, one bit per event field
  input wire logic [13:0] pulse,
  input wire logic [7:0] cyl,
  // Events into the block
  output frsf_pkg::frsf_events_s ev
);
  logic [7:0] last_cyl = 8'h00;

  // One-cycle pulses; the cylinder bus shows junk when not valid
  always_ff @(posedge aclk)
  begin
    ev <= {pulse, pulse[0] ? cyl : ~last_cyl};
    if (pulse[0])
    begin
      last_cyl <= cyl;
    end
  end
endmodule : frsf_drive_model

// ### bench/frsf_test.sv
// Self-checking bench for the result status flag block
`timescale 1ns/1ps
module frsf_test;
  // Event masks in struct field order
  localparam logic [13:0] M_PAST = 14'h2000;
  localparam logic [13:0] M_IDCRC = 14'h1000;
  localparam logic [13:0] M_DCRC = 14'h0800;
  localparam logic [13:0] M_LATE = 14'h0400;
  localparam logic [13:0] M_MISS = 14'h0200;
  localparam logic [13:0] M_IDRD = 14'h0100;
  localparam logic [13:0] M_START = 14'h0080;
  localparam logic [13:0] M_IDX = 14'h0040;
  localparam logic [13:0] M_MARK = 14'h0020;
  localparam logic [13:0] M_DEL = 14'h0010;
  localparam logic [13:0] M_EQ = 14'h0008;
  localparam logic [13:0] M_NONE = 14'h0004;
  localparam logic [13:0] M_DMM = 14'h0002;
  localparam logic [13:0] M_CYL = 14'h0001;
  localparam logic [13:0] M_ALL = 14'h3fdf;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic cmd_start = 1'b0;
  frsf_pkg::frsf_cmd_e cmd_kind = frsf_pkg::CMD_OTHER;
  logic cmd_done = 1'b0;
  logic prot = 1'b0;
  logic [13:0] pulse = 14'h0;
  logic [7:0] cyl = 8'h00;
  logic [7:0] tcyl = 8'h03;
  frsf_pkg::frsf_events_s ev;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [31:0] d;
  logic [1:0] r;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;

  // Clock of 50 ns period
  always #25 aclk = ~aclk;

  frsf_top i_frsf_top (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cmd_start(cmd_start), .cmd_kind(cmd_kind), .cmd_done(cmd_done), .target_cyl(tcyl),
    .protect_tab_input(prot), .ev(ev), .irq(irq));

  frsf_drive_model i_frsf_drive_model (.aclk(aclk), .pulse(pulse), .cyl(cyl), .ev(ev));

  task conclude;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Register write; address and data released as each is taken
  task wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    logic aw, w;
    @(posedge aclk); // One idle edge between transfers
    aw = 1'b0;
    w = 1'b0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge aclk);
      if (awvalid && awready)
      begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready)
      begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr

  // Register read
  task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk); // One idle edge between transfers
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd

  // One command with two event cycles, then the result bytes are read back
  task run(input frsf_pkg::frsf_cmd_e k, input logic p, input logic [13:0] m1,
    input logic [13:0] m2, input logic [7:0] c, input logic [7:0] e1, input logic [7:0] e2);
    logic [1:0] t;
    t = (e1 != 8'h00 || (e2 & frsf_pkg::S2_ERROR_MASK) != 8'h00) ?
      frsf_pkg::TERM_ABNORMAL : frsf_pkg::TERM_NORMAL;
    @(posedge aclk);
    cmd_start <= 1'b1;
    cmd_kind <= k;
    prot <= p;
    @(posedge aclk);
    cmd_start <= 1'b0;
    pulse <= m1;
    cyl <= c;
    @(posedge aclk);
    pulse <= m2;
    @(posedge aclk);
    pulse <= 14'h0;
    cmd_done <= 1'b1;
    @(posedge aclk);
    cmd_done <= 1'b0;
    prot <= 1'b0;
    repeat (3) @(posedge aclk);
    rd(8'h08, d, r);
    chk("command status", d, {24'h0, t, 6'h02});
    rd(8'h00, d, r);
    chk("status one", d, {24'h0, e1});
    rd(8'h04, d, r);
    chk("status two", d, {24'h0, e2});
  endtask : run

  // Cycle ceiling against hangs
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_count++;
      conclude();
    end
  end

  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00, d, r);
    chk("reset status one", d, 32'h0);
    rd(8'h20, d, r);
    chk("unmapped read resp", {30'h0, r}, {30'h0, frsf_pkg::RESP_SLVERR});
    wr(8'h20, 32'h1, r);
    chk("unmapped write resp", {30'h0, r}, {30'h0, frsf_pkg::RESP_SLVERR});
    wr(8'h00, 32'hff, r);
    chk("ro write resp", {30'h0, r}, {30'h0, frsf_pkg::RESP_OKAY});
    run(frsf_pkg::CMD_READ_DATA, 1'b0, M_PAST, 14'h0, 8'h00, 8'h80, 8'h00);
    run(frsf_pkg::CMD_READ_DATA, 1'b0, M_IDCRC, 14'h0, 8'h00, 8'h20, 8'h00);
    run(frsf_pkg::CMD_READ_DATA, 1'b0, M_DCRC, 14'h0, 8'h00, 8'h20, 8'h20);
    run(frsf_pkg::CMD_READ_DATA, 1'b0, M_LATE, 14'h0, 8'h00, 8'h10, 8'h00);
    run(frsf_pkg::CMD_SCAN, 1'b0, M_MISS, 14'h0, 8'h00, 8'h04, 8'h00);
    run(frsf_pkg::CMD_WRITE_DELETED, 1'b0, 14'h0, M_MISS, 8'h00, 8'h04, 8'h00);
    run(frsf_pkg::CMD_READ_ID, 1'b0, M_IDRD, 14'h0, 8'h00, 8'h04, 8'h00);
    run(frsf_pkg::CMD_READ_TRACK, 1'b0, M_START, 14'h0, 8'h00, 8'h04, 8'h00);
    run(frsf_pkg::CMD_WRITE_DATA, 1'b1, 14'h0, 14'h0, 8'h00, 8'h02, 8'h00);
    run(frsf_pkg::CMD_FORMAT_TRACK, 1'b1, 14'h0, 14'h0, 8'h00, 8'h02, 8'h00);
    run(frsf_pkg::CMD_READ_DATA, 1'b1, 14'h0, 14'h0, 8'h00, 8'h00, 8'h00);
    run(frsf_pkg::CMD_OTHER, 1'b1, M_MISS | M_IDRD | M_START | M_DEL, M_EQ | M_NONE,
      8'h00, 8'h00, 8'h00);
    run(frsf_pkg::CMD_READ_ID, 1'b1, M_MISS | M_START, M_DEL | M_EQ,
      8'h00, 8'h00, 8'h00);
    run(frsf_pkg::CMD_READ_DATA, 1'b0, M_IDX, M_IDX, 8'h00, 8'h01, 8'h01);
    run(frsf_pkg::CMD_READ_DATA, 1'b0, M_IDX, M_MARK, 8'h00, 8'h00, 8'h00);
    run(frsf_pkg::CMD_READ_DATA, 1'b0, M_DEL, 14'h0, 8'h00, 8'h00, 8'h40);
    run(frsf_pkg::CMD_SCAN, 1'b0, M_EQ, 14'h0, 8'h00, 8'h00, 8'h08);
    run(frsf_pkg::CMD_SCAN, 1'b0, M_NONE, 14'h0, 8'h00, 8'h00, 8'h04);
    run(frsf_pkg::CMD_READ_DATA, 1'b0, M_DMM, 14'h0, 8'h00, 8'h00, 8'h01);
    run(frsf_pkg::CMD_READ_DATA, 1'b0, M_CYL, M_MISS, 8'h05, 8'h04, 8'h10);
    run(frsf_pkg::CMD_READ_DATA, 1'b0, M_CYL, M_MISS, 8'h03, 8'h04, 8'h00);
    run(frsf_pkg::CMD_READ_DATA, 1'b0, M_CYL, M_MISS, 8'hff, 8'h04, 8'h12);
    // Target cylinder moved to the bad value: equal cylinders flag no track mismatch or bad track
    tcyl <= 8'hff;
    run(frsf_pkg::CMD_READ_DATA, 1'b0, M_CYL, M_MISS, 8'hff, 8'h04, 8'h00);
    tcyl <= 8'h03;
    run(frsf_pkg::CMD_SCAN, 1'b0, M_ALL, M_ALL, 8'hff, 8'hb5, 8'h7f);
    wr(8'h14, 32'h3, r);
    run(frsf_pkg::CMD_READ_DATA, 1'b0, M_LATE, 14'h0, 8'h00, 8'h10, 8'h00);
    chk("irq raised", {31'h0, irq}, 32'h1);
    rd(8'h0c, d, r);
    chk("irq status", d, 32'h3);
    wr(8'h10, 32'h3, r);
    repeat (2) @(posedge aclk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    wr(8'h14, 32'h0, r);
    run(frsf_pkg::CMD_READ_DATA, 1'b0, 14'h0, 14'h0, 8'h00, 8'h00, 8'h00);
    rd(8'h0c, d, r);
    chk("irq normal end", d, 32'h1);
    chk("irq masked", {31'h0, irq}, 32'h0);
    conclude();
  end
endmodule : frsf_test
